// [include/cuto_map.svh]
// constants of the card-link timeout counter group
// assumes one ETU tick per elementary time unit, made outside
`ifndef CUTO_MAP_SVH
`define CUTO_MAP_SVH

// configuration codes
`define CUTO_CODE_STOP   8'h00
`define CUTO_CODE_05     8'h05
`define CUTO_CODE_07     8'h07
`define CUTO_CODE_61     8'h61
`define CUTO_CODE_65     8'h65
`define CUTO_CODE_71     8'h71
`define CUTO_CODE_73     8'h73
`define CUTO_CODE_75     8'h75
`define CUTO_CODE_77     8'h77
`define CUTO_CODE_7C     8'h7c
`define CUTO_CODE_F3     8'hf3
`define CUTO_CODE_F7     8'hf7

// reset values
`define CUTO_CODE_RST    8'h00
`define CUTO_BYTE_ZERO   8'h00
`define CUTO_WIDE_ZERO   24'h000000

// halt window after the first start bit, in ETUs
`define CUTO_HALT_ETUS   4'hc
`define CUTO_HALT_LAST   4'hb

`endif

// [include/cuto_pkg.sv]
// types of the card-link timeout counter group
// assumes cuto_map.svh holds the numeric constants
package cuto_pkg;

	typedef logic [7:0] cuto_byte_t;

	// how the three bytes are wired
	typedef enum logic [2:0] {
		CUTO_L_SEP   = 3'h1,
		CUTO_L_PAIR  = 3'h2,
		CUTO_L_CHAIN = 3'h4
	} cuto_layout_e;

	// twelve-ETU halt window sequencing
	typedef enum logic [3:0] {
		CUTO_H_IDLE  = 4'h1,
		CUTO_H_ARMED = 4'h2,
		CUTO_H_COUNT = 4'h4,
		CUTO_H_DONE  = 4'h8
	} cuto_halt_e;

endpackage : cuto_pkg

// [hw/cuto_timeout.sv]
// timeout counter group of a contact card UART
// assumes etu_tick, start_bit and config_wr are one-cycle pulses on mclk
//
// How it works
// - pair reload rewritten mid-count takes effect only at next start bit (71h/75h) or next write (61h/65h).
// - code 73h runs independent bytes with counter 1 held stopped.
// - 73h/77h counter 2 loads on each start bit, flags at end.
// - counter 2 reload rewritten mid-count waits for next start bit.
// - 73h/77h counter 3 loads on the write itself, flags at end.
// - 75h/77h counter 1 auto-reloads from first start bit, flags each time.
// - code 75h pair 3:2 retriggers on start bits, flags counter 3.
// - code 77h runs auto, retriggered and immediate bytes together.
// - code 7Ch chains 3:2:1 into 24 bits, retriggered by start bits.
// - chain reload rewritten mid-count waits for next start bit.
// - code 00h stops every counter.
// - code F3h is 73h but bytes halt 12 ETUs after first start bit.
// - code F7h is 77h but bytes halt 12 ETUs after first start bit.
// - code 61h stops counter 1 and starts pair 3:2 on the write.
// - code 65h auto-reloads counter 1, pair 3:2 starts on the write.
// - code 05h stops pair 3:2, counter 1 keeps auto-reloading.
// - code 71h stops counter 1, pair 3:2 retriggered by start bits.
`timescale 1ns/10ps

`include "cuto_map.svh"

module cuto_timeout
	import cuto_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       etu_tick,
	input  wire logic       start_bit,
	input  wire logic       config_wr,
	input  wire logic [7:0] config_data,
	input  wire logic [7:0] timeout_reload_byte1,
	input  wire logic [7:0] timeout_reload_byte2,
	input  wire logic [7:0] timeout_reload_byte3,
	input  wire logic [2:0] expired_flag_clear,
	output logic      [7:0] timeout_config_code,
	output logic            counter1_expired_flag,
	output logic            counter2_expired_flag,
	output logic            counter3_expired_flag,
	output logic            timeout_irq,
	output logic      [2:0] byte_running,
	output logic            wide_running
);

	// decoded view of a code being written
	logic         d_c1_auto;
	logic         d_keep1;
	logic         d_c2_sb;
	logic         d_c3_imm;
	logic         d_wide_imm;
	logic         d_wide_sb;
	logic         d_halt;
	cuto_layout_e d_layout;
	// mode state
	logic         c1_auto;
	logic         c1_started;
	logic         c2_sb;
	logic         wide_sb;
	cuto_layout_e layout;
	cuto_layout_e cur_layout;
	cuto_halt_e   h_st;
	logic [3:0]   h_cnt;
	logic         halted;
	logic         halt_fire;
	// byte counters
	cuto_byte_t   cnt [3];
	logic         run_q [3];
	cuto_byte_t   rel [3];
	logic [2:0]   ld;
	logic [2:0]   stop;
	logic [2:0]   tc;
	logic [2:0]   auto_rl;
	logic [2:0]   set_flag;
	// chained counter
	logic [23:0]  wide_cnt;
	logic [23:0]  wide_rel;
	logic         wide_ld;
	logic         wide_stop;
	logic         wide_tc;

	// unknown codes decode as a full stop
	assign d_keep1    = config_data inside {`CUTO_CODE_05,
		`CUTO_CODE_07};
	assign d_c1_auto  = config_data inside {`CUTO_CODE_65, `CUTO_CODE_75,
		`CUTO_CODE_77, `CUTO_CODE_F7};
	assign d_c2_sb    = config_data inside {`CUTO_CODE_73, `CUTO_CODE_77,
		`CUTO_CODE_F3, `CUTO_CODE_F7};
	assign d_c3_imm   = d_c2_sb;
	assign d_wide_imm = config_data inside {`CUTO_CODE_61,
		`CUTO_CODE_65};
	assign d_wide_sb  = config_data inside {`CUTO_CODE_71, `CUTO_CODE_75,
		`CUTO_CODE_7C};
	assign d_halt     = config_data inside {`CUTO_CODE_F3,
		`CUTO_CODE_F7};

	always_comb begin
		d_layout = CUTO_L_SEP;
		if (config_data == `CUTO_CODE_7C) begin
			d_layout = CUTO_L_CHAIN;
		end else if (config_data inside {`CUTO_CODE_05, `CUTO_CODE_61,
			`CUTO_CODE_65, `CUTO_CODE_71, `CUTO_CODE_75}) begin
			d_layout = CUTO_L_PAIR;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			timeout_config_code <= `CUTO_CODE_RST;
			layout              <= CUTO_L_SEP;
			c2_sb               <= 1'b0;
			wide_sb             <= 1'b0;
		end else if (config_wr) begin
			timeout_config_code <= config_data;
			layout              <= d_layout;
			c2_sb               <= d_c2_sb;
			wide_sb             <= d_wide_sb;
		end
	end

	// counter 1 keeps its mode across 05h and 07h
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			c1_auto    <= 1'b0;
			c1_started <= 1'b0;
		end else if (config_wr) begin
			if (!d_keep1) begin
				c1_auto    <= d_c1_auto;
				c1_started <= 1'b0;
			end
		end else if (ld[0]) begin
			c1_started <= 1'b1;
		end
	end

	// twelve-ETU halt window
	assign halted    = (h_st == CUTO_H_DONE);
	assign halt_fire = (h_st == CUTO_H_COUNT) && etu_tick && !config_wr &&
		(h_cnt == `CUTO_HALT_LAST);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			h_st  <= CUTO_H_IDLE;
			h_cnt <= 4'h0;
		end else if (config_wr) begin
			h_st  <= d_halt ? CUTO_H_ARMED : CUTO_H_IDLE;
			h_cnt <= 4'h0;
		end else begin
			unique case (h_st)
				CUTO_H_IDLE: begin
					h_cnt <= 4'h0;
				end
				CUTO_H_ARMED: begin
					if (start_bit) begin
						h_st  <= CUTO_H_COUNT;
						h_cnt <= 4'h0;
					end
				end
				CUTO_H_COUNT: begin
					if (halt_fire) begin
						h_st <= CUTO_H_DONE;
					end else if (etu_tick) begin
						h_cnt <= h_cnt + 4'h1;
					end
				end
				CUTO_H_DONE: begin
					h_cnt <= `CUTO_HALT_ETUS;
				end
			endcase
		end
	end

	assign rel[0] = timeout_reload_byte1;
	assign rel[1] = timeout_reload_byte2;
	assign rel[2] = timeout_reload_byte3;
	// reloads are sampled only at a load or a counter 1 auto-reload, so rewrites never touch a count
	// a start bit on the halting tick must not restart a byte
	assign ld[0] = c1_auto && !c1_started && start_bit && !config_wr &&
		!halted && !halt_fire;
	assign ld[1] = c2_sb && start_bit && !config_wr && !halted &&
		!halt_fire;
	assign ld[2] = config_wr && d_c3_imm;
	assign stop[0] = (config_wr && !d_keep1) || halt_fire;
	assign stop[1] = config_wr || halt_fire;
	assign stop[2] = (config_wr && !d_c3_imm) || halt_fire;
	assign auto_rl = {1'b0, 1'b0, c1_auto};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_byte
			assign tc[gi] = run_q[gi] && etu_tick &&
				(cnt[gi] <= 8'h01);
			assign byte_running[gi] = run_q[gi];
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					cnt[gi]   <= `CUTO_BYTE_ZERO;
					run_q[gi] <= 1'b0;
				end else if (stop[gi]) begin
					run_q[gi] <= 1'b0;
				end else if (ld[gi]) begin
					cnt[gi]   <= rel[gi];
					run_q[gi] <= 1'b1;
				end else if (tc[gi]) begin
					if (auto_rl[gi]) begin
						cnt[gi] <= rel[gi];
					end else begin
						cnt[gi]   <= `CUTO_BYTE_ZERO;
						run_q[gi] <= 1'b0;
					end
				end else if (run_q[gi] && etu_tick) begin
					cnt[gi] <= cnt[gi] - 8'h01;
				end
			end
		end
	endgenerate

	// chained counter, counter 3 the high byte
	assign cur_layout = config_wr ? d_layout : layout;

	always_comb begin
		wide_rel = `CUTO_WIDE_ZERO;
		if (cur_layout == CUTO_L_CHAIN) begin
			wide_rel = {timeout_reload_byte3, timeout_reload_byte2,
				timeout_reload_byte1};
		end else if (cur_layout == CUTO_L_PAIR) begin
			wide_rel = {8'h00, timeout_reload_byte3,
				timeout_reload_byte2};
		end
	end

	assign wide_ld   = (config_wr && d_wide_imm) ||
		(wide_sb && start_bit && !config_wr);
	assign wide_stop = config_wr && !d_wide_imm;
	assign wide_tc   = wide_running && etu_tick &&
		(wide_cnt <= 24'h000001);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wide_cnt     <= `CUTO_WIDE_ZERO;
			wide_running <= 1'b0;
		end else if (wide_stop) begin
			wide_running <= 1'b0;
		end else if (wide_ld) begin
			wide_cnt     <= wide_rel;
			wide_running <= 1'b1;
		end else if (wide_tc) begin
			wide_cnt     <= `CUTO_WIDE_ZERO;
			wide_running <= 1'b0;
		end else if (wide_running && etu_tick) begin
			wide_cnt <= wide_cnt - 24'h000001;
		end
	end

	// sticky flags, a set beats a clear in the same cycle
	assign set_flag = {tc[2] || wide_tc, tc[1], tc[0]};

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			counter1_expired_flag <= 1'b0;
			counter2_expired_flag <= 1'b0;
			counter3_expired_flag <= 1'b0;
			timeout_irq           <= 1'b0;
		end else begin
			counter1_expired_flag <= set_flag[0] ||
				(counter1_expired_flag && !expired_flag_clear[0]);
			counter2_expired_flag <= set_flag[1] ||
				(counter2_expired_flag && !expired_flag_clear[1]);
			counter3_expired_flag <= set_flag[2] ||
				(counter3_expired_flag && !expired_flag_clear[2]);
			timeout_irq           <= |set_flag;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_wr_73_77;
		config_wr && (config_data == `CUTO_CODE_73 ||
			config_data == `CUTO_CODE_77);
	endsequence
	sequence s_halt_go;
		h_st == CUTO_H_COUNT && halt_fire;
	endsequence

	c3_immediate_a: assert property (s_wr_73_77 |=>
		run_q[2] && cnt[2] == $past(timeout_reload_byte3))
		else $error("counter 3 did not start on the write");
	c1_held_a: assert property (s_wr_73_77 ##1 !config_wr |->
		!run_q[0] && !wide_running)
		else $error("counter 1 or pair ran in 73h or 77h");
	c2_trigger_a: assert property (ld[1] |=>
		run_q[1] && cnt[1] == $past(timeout_reload_byte2))
		else $error("counter 2 missed its start-bit load");
	c2_keep_a: assert property (run_q[1] && !etu_tick && !ld[1] &&
		!stop[1] |=> $stable(cnt[1]))
		else $error("counter 2 count disturbed");
	c1_autoreload_a: assert property (tc[0] && c1_auto && !stop[0] |=>
		run_q[0] && cnt[0] == $past(timeout_reload_byte1) &&
		counter1_expired_flag)
		else $error("counter 1 did not auto-reload");
	pair_load_a: assert property (wide_ld && cur_layout == CUTO_L_PAIR |=>
		wide_cnt == {8'h00, $past(timeout_reload_byte3),
		$past(timeout_reload_byte2)})
		else $error("pair loaded a wrong value");
	chain_load_a: assert property (wide_ld && cur_layout == CUTO_L_CHAIN |=>
		wide_cnt == {$past(timeout_reload_byte3),
		$past(timeout_reload_byte2), $past(timeout_reload_byte1)})
		else $error("chain loaded a wrong value");
	wide_keep_a: assert property (wide_running && !etu_tick &&
		!wide_ld && !wide_stop |=> $stable(wide_cnt))
		else $error("chained count disturbed");
	// a start bit on the terminal tick restarts the chain at once
	wide_flag_a: assert property (wide_tc && !config_wr |=>
		counter3_expired_flag && timeout_irq &&
		wide_running == $past(wide_ld))
		else $error("chained end did not flag counter 3");
	stop_all_a: assert property (config_wr &&
		config_data == `CUTO_CODE_STOP |=> !run_q[0] && !run_q[1] &&
		!run_q[2] && !wide_running)
		else $error("stop code left a counter running");
	halt_end_a: assert property (s_halt_go |=>
		!run_q[0] && !run_q[1] && !run_q[2] && halted ##1 !run_q[1])
		else $error("bytes ran past the halt window");
	imm_pair_a: assert property (config_wr &&
		config_data == `CUTO_CODE_61 |=> wide_running && !run_q[0])
		else $error("61h did not start the pair alone");
	step_once_a: assert property (run_q[2] && etu_tick && !tc[2] &&
		!stop[2] && !ld[2] |=> cnt[2] == $past(cnt[2]) - 8'h01)
		else $error("counter 3 did not step by one");

endmodule : cuto_timeout

// [verif/cuto_card_model.sv]
// card model: characters on the I/O line, seen as start-bit pulses
// assumes the bench opens slots through allow, sampled just after mclk rises
`timescale 1ns/10ps

module cuto_card_model (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic allow,
	output logic      start_bit
);
	initial start_bit = 1'b0;

	// replies and echoed reader characters give the same pulse
	always @(posedge mclk) begin
		#1;
		start_bit = resetn && allow && ($urandom_range(7) == 0);
	end
endmodule : cuto_card_model

// [verif/cuto_timeout_tb_top.sv]
// self-checking bench of the timeout counter group
// assumes cuto_card_model drives start bits only in slots opened here
`timescale 1ns/10ps

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
	num_errors++; $display("wrong value at %0t: %h not %h", $time, got, exp); \
	end end

module cuto_timeout_tb_top
	import cuto_pkg::*;
;
	logic       mclk = 1'b0;
	logic       resetn, etu_tick, start_bit, config_wr, quiet, allow;
	cuto_byte_t config_data, reload1, reload2, reload3, timeout_config_code;
	logic [2:0] expired_flag_clear, byte_running, flags;
	logic       counter1_expired_flag, counter2_expired_flag;
	logic       counter3_expired_flag, timeout_irq, wide_running;
	logic [1:0] ph = 2'h0;
	int         num_errors, n_tests, cycles, c1, c2, c3, cw, hc;
	int unsigned seed_val;
	bit         r1, r2, r3, rw, arm1, trig2, wtrig, w24, hon, hgo, hdone;
	bit         t1, t2, t3, tw, m_f1, m_f2, m_f3, m_irq, auto1, imm3;
	bit   [7:0] m_code;
	cuto_byte_t codes [13] = '{8'h73, 8'h77, 8'h07, 8'h75, 8'h7c, 8'h61,
		8'h65, 8'h05, 8'h71, 8'hf3, 8'hf7, 8'h00, 8'h42};

	cuto_timeout i_cuto_timeout (
		.mclk                  (mclk),
		.resetn                (resetn),
		.etu_tick              (etu_tick),
		.start_bit             (start_bit),
		.config_wr             (config_wr),
		.config_data           (config_data),
		.timeout_reload_byte1  (reload1),
		.timeout_reload_byte2  (reload2),
		.timeout_reload_byte3  (reload3),
		.expired_flag_clear    (expired_flag_clear),
		.timeout_config_code   (timeout_config_code),
		.counter1_expired_flag (counter1_expired_flag),
		.counter2_expired_flag (counter2_expired_flag),
		.counter3_expired_flag (counter3_expired_flag),
		.timeout_irq           (timeout_irq),
		.byte_running          (byte_running),
		.wide_running          (wide_running)
	);

	cuto_card_model i_cuto_card_model (
		.mclk      (mclk),
		.resetn    (resetn),
		.allow     (allow),
		.start_bit (start_bit)
	);

	assign allow = !quiet && ph == 2'h2;
	assign flags = {counter3_expired_flag, counter2_expired_flag,
		counter1_expired_flag};

	always #4 mclk = ~mclk;

	// ticks and writes never share a cycle
	always @(posedge mclk) ph <= ph + 2'h1;

	always @(posedge mclk) begin
		#1;
		etu_tick = ph == 2'h0;
		expired_flag_clear = ($urandom_range(15) == 0) ?
			3'($urandom_range(7)) : 3'h0;
	end

	task automatic step(ref bit run, ref int cnt, ref bit hit);
		if (run && cnt <= 1) begin
			hit = 1'b1;
			run = 1'b0;
		end else if (run) begin
			cnt--;
		end
	endtask : step

	always @(posedge mclk or negedge resetn) begin
		{t1, t2, t3, tw} = '0;
		if (!resetn) begin
			{r1, r2, r3, rw, arm1, trig2, wtrig, w24, hon, hgo, hdone} = '0;
			{m_f1, m_f2, m_f3, m_irq} = '0;
			m_code = 8'h00;
		end else begin
			if (config_wr) begin
				m_code = config_data;
				auto1 = config_data inside {8'h65, 8'h75, 8'h77, 8'hf7};
				imm3 = config_data inside {8'h73, 8'h77, 8'hf3, 8'hf7};
				hon = config_data inside {8'hf3, 8'hf7};
				{hgo, hdone, hc} = '0;
				if (!(config_data inside {8'h05, 8'h07})) begin
					r1 = 1'b0;
					arm1 = auto1;
				end
				trig2 = imm3;
				r2 = 1'b0;
				r3 = imm3;
				c3 = reload3;
				wtrig = config_data inside {8'h71, 8'h75, 8'h7c};
				w24 = config_data == 8'h7c;
				rw = config_data inside {8'h61, 8'h65};
				cw = {reload3, reload2};
			end else if (start_bit) begin
				if (arm1 && !hdone) begin
					r1 = 1'b1;
					arm1 = 1'b0;
					c1 = reload1;
				end
				if (trig2 && !hdone) begin
					r2 = 1'b1;
					c2 = reload2;
				end
				if (wtrig) begin
					rw = 1'b1;
					cw = w24 ? {reload3, reload2, reload1} : {reload3, reload2};
				end
				if (hon) hgo = 1'b1;
			end else if (etu_tick) begin
				step(r1, c1, t1);
				if (t1) begin
					r1 = 1'b1;
					c1 = reload1;
				end
				step(r2, c2, t2);
				step(r3, c3, t3);
				step(rw, cw, tw);
				if (hgo && !hdone) hc++;
				if (hc == 12 && !hdone) begin
					{hdone, r1, r2, r3, arm1} = 5'b10000;
				end
			end
			m_f1 = t1 | (m_f1 & !expired_flag_clear[0]);
			m_f2 = t2 | (m_f2 & !expired_flag_clear[1]);
			m_f3 = t3 | tw | (m_f3 & !expired_flag_clear[2]);
			m_irq = t1 | t2 | t3 | tw;
		end
	end

	always @(negedge mclk) begin
		`CHK(timeout_config_code, m_code)
		`CHK(byte_running, {r3, r2, r1})
		`CHK(wide_running, rw)
		`CHK(flags, {m_f3, m_f2, m_f1})
		`CHK(timeout_irq, m_irq)
	end

	task automatic wr(input cuto_byte_t cd);
		do begin
			@(posedge mclk);
			#1;
		end while (ph != 2'h2);
		config_wr = 1'b1;
		config_data = cd;
		@(posedge mclk);
		#1;
		config_wr = 1'b0;
	endtask : wr

	task automatic run_code(input cuto_byte_t cd);
		quiet = 1'b1;
		if (!(cd inside {8'h05, 8'h07})) begin
			wr(8'h00);
			reload1 = cd[7] ? 8'h05 : 8'h01 + 8'($urandom_range(14));
			reload2 = (cd == 8'h7c) ? 8'h00 : 8'h01 + 8'($urandom_range(14));
			reload3 = (cd == 8'h7c) ? 8'h00 : 8'($urandom_range(1));
		end
		wr(cd);
		quiet = 1'b0;
		repeat (1200) begin
			@(posedge mclk);
			#1;
			if ($urandom_range(63) == 0) begin
				if (cd == 8'h7c) begin
					reload1 = 8'h01 + 8'($urandom_range(14));
				end else if (cd inside {8'h73, 8'h77, 8'hf3, 8'hf7, 8'h75,
					8'h71}) begin
					reload2 = 8'h01 + 8'($urandom_range(14));
				end
			end
		end
	endtask : run_code

	task automatic conclude;
		if (num_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			conclude();
		end
	end

	initial begin
		seed_val = $urandom(87450);
		{resetn, etu_tick, config_wr, quiet} = 4'b0001;
		{config_data, reload1, reload2, reload3} = '0;
		expired_flag_clear = 3'h0;
		repeat (16) @(posedge mclk);
		#1;
		resetn = 1'b1;
		foreach (codes[i]) run_code(codes[i]);
		conclude();
	end
endmodule : cuto_timeout_tb_top
